// ---- core/rtc_defines.vh ----
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH

// Register byte offsets on the peripheral bus
`define OFS_COUNTER_VALUE    8'h00
`define OFS_MATCH_VALUE      8'h04
`define OFS_LOAD_VALUE       8'h08
`define OFS_COUNTER_CONTROL  8'h0C
`define OFS_IRQ_STATUS       8'h10
`define OFS_RAW_IRQ_STATUS   8'h14
`define OFS_IRQ_ACKNOWLEDGE  8'h18
`define OFS_COMP_VERSION     8'h1C

// Address bits decoded by the slave
`define ADDR_W               8

// Control register field positions
`define CTL_WRAP_EN_BIT      3
`define CTL_COUNT_EN_BIT     2
`define CTL_IRQ_MASK_BIT     1
`define CTL_IRQ_EN_BIT       0
`define CTL_W                4

// Reset values
`define RST_WORD             32'h00000000
`define RST_CTL              4'h0

// Neutral version word, value arbitrary
`define VERSION_WORD_DEFAULT 32'h00000001

`endif

// ---- core/rtc_tick_sync.v ----
`timescale 1ns/1ps

module rtc_tick_sync (
    // Clock and reset
    input  wire core_clk_i,
    input  wire arst_n_i,
    // Slow counter clock, asynchronous to core_clk_i
    input  wire rtc_clk_i,
    // One-cycle pulse per rising edge of rtc_clk_i
    output wire tick_o
);

    reg sync1_reg;
    reg sync2_reg;
    reg prev_reg;

    // Two-stage synchroniser, then edge memory; only sync2 feeds logic
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end else begin
            sync1_reg <= rtc_clk_i;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // Rising edge seen on synchronised level
    assign tick_o = sync2_reg & ~prev_reg;

endmodule

// ---- core/rtc_counter_match_regs.v ----
`timescale 1ns/1ps
`include "rtc_defines.vh"

module rtc_counter_match_regs #(
    parameter [31:0] VERSION_WORD = `VERSION_WORD_DEFAULT
) (
    // Clock and reset
    input  wire                  core_clk_i,
    input  wire                  arst_n_i,
    // Prescaled counter clock pin
    input  wire                  rtc_clk_i,
    // APB slave
    input  wire                  psel_i,
    input  wire                  penable_i,
    input  wire                  pwrite_i,
    input  wire [`ADDR_W-1:0]    paddr_i,
    input  wire [31:0]           pwdata_i,
    output wire [31:0]           prdata_o,
    output wire                  pready_o,
    output wire                  pslverr_o,
    // Match interrupt line
    output wire                  irq_o
);

    // Counter state
    reg  [31:0]         counter_value_reg;
    reg  [31:0]         counter_value_next;
    reg  [31:0]         match_value_reg;
    reg  [31:0]         load_value_reg;
    reg  [`CTL_W-1:0]   counter_control_reg;
    reg                 load_pending_reg;

    // Interrupt state
    reg                 raw_irq_reg;
    reg                 ack_pending_reg;
    reg                 irq_line_reg;
    reg                 irq_line_next;

    // Bus answer flops and their combinational inputs
    reg  [31:0]         prdata_reg;
    reg  [31:0]         prdata_next;
    reg                 pready_reg;
    reg                 pslverr_reg;
    reg                 addr_hit;

    // Decoded control fields, bus phase qualifiers and interrupt terms
    wire                wrap_en;
    wire                count_en;
    wire                irq_mask;
    wire                irq_enable;
    wire                tick;
    wire                setup_phase;
    wire                access_phase;
    wire                wr_access;
    wire                rd_setup;
    wire                ack_read;
    wire                at_match;
    wire                match_event;
    wire                raw_irq_status;
    wire                irq_status;

    assign wrap_en    = counter_control_reg[`CTL_WRAP_EN_BIT];
    assign count_en   = counter_control_reg[`CTL_COUNT_EN_BIT];
    assign irq_mask   = counter_control_reg[`CTL_IRQ_MASK_BIT];
    assign irq_enable = counter_control_reg[`CTL_IRQ_EN_BIT];

    // synchronised counter tick
    // Pin passes two flops before any logic sees it
    rtc_tick_sync u_tick_sync (
        .core_clk_i (core_clk_i),
        .arst_n_i   (arst_n_i),
        .rtc_clk_i  (rtc_clk_i),
        .tick_o     (tick)
    );

    // Bus phase qualifiers
    assign setup_phase  = psel_i & ~penable_i;
    assign access_phase = psel_i & penable_i;
    assign wr_access    = access_phase & pwrite_i;
    assign rd_setup     = setup_phase & ~pwrite_i;
    assign ack_read     = access_phase & ~pwrite_i &
                          (paddr_i == `OFS_IRQ_ACKNOWLEDGE);

    // Match compare against the count currently held
    assign at_match = (counter_value_reg == match_value_reg);

    // match sets interrupt on a tick
    // driven by tick alone, no bus activity needed
    assign match_event = tick & at_match & irq_enable;

    // raw condition, independent of the mask
    assign raw_irq_status = raw_irq_reg;

    // mask bit set hides the interrupt
    assign irq_status = raw_irq_reg & ~irq_mask;

    // Next counter value on a tick
    always @* begin
        counter_value_next = counter_value_reg;
        if (tick) begin
            if (load_pending_reg) begin
                counter_value_next = load_value_reg;
            end else if (count_en) begin
                if (wrap_en && at_match) begin
                    counter_value_next = `RST_WORD;
                end else begin
                    // plus one, all-ones rolls to zero
                    counter_value_next = counter_value_reg + 32'h00000001;
                end
            end
        end
    end

    // Counter register; single clock so no partial word is ever seen
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            counter_value_reg <= `RST_WORD;
        end else begin
            counter_value_reg <= counter_value_next;
        end
    end

    // Software-written registers
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            match_value_reg     <= `RST_WORD;
            load_value_reg      <= `RST_WORD;
            counter_control_reg <= `RST_CTL;
        end else if (wr_access) begin
            case (paddr_i)
                `OFS_MATCH_VALUE: begin
                    match_value_reg <= pwdata_i;
                end
                `OFS_LOAD_VALUE: begin
                    load_value_reg <= pwdata_i;
                end
                `OFS_COUNTER_CONTROL: begin
                    // Upper bits are reserved and dropped
                    counter_control_reg <= pwdata_i[`CTL_W-1:0];
                end
                default: begin
                    // Read-only offsets ignore writes
                    counter_control_reg <= counter_control_reg;
                end
            endcase
        end
    end

    // Load request waits for the next tick, so it aligns to the counter clock
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            load_pending_reg <= 1'b0;
        end else if (wr_access && (paddr_i == `OFS_LOAD_VALUE)) begin
            // request transfer of the new word
            load_pending_reg <= 1'b1;
        end else if (tick) begin
            load_pending_reg <= 1'b0;
        end
    end

    // Acknowledge held until the next tick clears the status bit
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_pending_reg <= 1'b0;
        end else if (ack_read) begin
            ack_pending_reg <= 1'b1;
        end else if (tick) begin
            ack_pending_reg <= 1'b0;
        end
    end

    // Raw interrupt flag; a match on the clearing tick wins
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            raw_irq_reg <= 1'b0;
        end else if (match_event) begin
            raw_irq_reg <= 1'b1;
        end else if (tick && ack_pending_reg) begin
            // status clears on the first counter tick after the read
            raw_irq_reg <= 1'b0;
        end
    end

    // Interrupt line: dropped at once on acknowledge unless an unmasked match lands in the same cycle, status lags behind
    always @* begin
        irq_line_next = irq_status & ~ack_pending_reg & ~ack_read;
        if (match_event && !irq_mask) begin
            irq_line_next = 1'b1;
        end else if (ack_read) begin
            irq_line_next = 1'b0;
        end
    end

    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_line_reg <= 1'b0;
        end else begin
            irq_line_reg <= irq_line_next;
        end
    end

    // Address hit check for the error answer
    always @* begin
        case (paddr_i)
            `OFS_COUNTER_VALUE,
            `OFS_MATCH_VALUE,
            `OFS_LOAD_VALUE,
            `OFS_COUNTER_CONTROL,
            `OFS_IRQ_STATUS,
            `OFS_RAW_IRQ_STATUS,
            `OFS_IRQ_ACKNOWLEDGE,
            `OFS_COMP_VERSION: begin
                addr_hit = 1'b1;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // Read mux, sampled in the setup phase so data is flopped for access
    always @* begin
        prdata_next = `RST_WORD;
        case (paddr_i)
            `OFS_COUNTER_VALUE: begin
                prdata_next = counter_value_reg;
            end
            `OFS_MATCH_VALUE: begin
                prdata_next = match_value_reg;
            end
            `OFS_LOAD_VALUE: begin
                prdata_next = load_value_reg;
            end
            `OFS_COUNTER_CONTROL: begin
                prdata_next[`CTL_W-1:0] = counter_control_reg;
            end
            `OFS_IRQ_STATUS: begin
                prdata_next[0] = irq_status;
            end
            `OFS_RAW_IRQ_STATUS: begin
                prdata_next[0] = raw_irq_status;
            end
            `OFS_COMP_VERSION: begin
                prdata_next = VERSION_WORD;
            end
            default: begin
                // Acknowledge and unmapped read as zero
                prdata_next = `RST_WORD;
            end
        endcase
    end

    // Bus answer: ready in the access phase, never a wait state
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_reg  <= `RST_WORD;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= setup_phase;
            pslverr_reg <= setup_phase & ~addr_hit;
            if (rd_setup) begin
                prdata_reg <= prdata_next;
            end else if (!psel_i) begin
                // Idle bus shows zero data
                prdata_reg <= `RST_WORD;
            end
        end
    end

    // Outputs straight from flops
    assign prdata_o  = prdata_reg;
    assign pready_o  = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign irq_o     = irq_line_reg;

endmodule

// ---- testbench/rtc_counter_match_regs_sva.sv ----
`timescale 1ns/1ps
module rtc_counter_match_regs_sva (
    // Clock and reset
    input wire logic        core_clk_i,
    input wire logic        arst_n_i,
    // Bus and interrupt
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        irq_o
);
    reg  [3:0]  ctl_reg;
    reg  [31:0] match_reg;
    wire        wr_go = psel_i && penable_i && pwrite_i;
    wire        rd_setup = psel_i && !penable_i && !pwrite_i;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    // Shadow copies, so readback and mask can be judged from bus traffic alone
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctl_reg   <= 4'h0;
            match_reg <= 32'h0;
        end else if (wr_go && paddr_i == 8'h0C) begin
            ctl_reg   <= pwdata_i[3:0];
        end else if (wr_go && paddr_i == 8'h04) begin
            match_reg <= pwdata_i;
        end
    end

    pready_a: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    ready_once_a: assert property (pready_o |=> !pready_o)
        else $error("ready held two cycles");
    unmapped_err_a: assert property (psel_i && !penable_i && paddr_i > 8'h1C |=> pslverr_o)
        else $error("no error on unmapped offset");
    match_rd_a: assert property (rd_setup && paddr_i == 8'h04 |=> prdata_o == match_reg)
        else $error("match readback wrong");
    ctl_rd_a: assert property (rd_setup && paddr_i == 8'h0C |=> prdata_o == {28'h0, ctl_reg})
        else $error("control readback wrong");
    ack_drop_a: assert property (psel_i && penable_i && !pwrite_i && paddr_i == 8'h18
        |-> ##[1:2] !irq_o) else $error("line kept after acknowledge");
    mask_hold_a: assert property (ctl_reg[1] && $past(ctl_reg[1], 2) |-> !irq_o)
        else $error("line high while masked");
    ien_gate_a: assert property ($rose(irq_o) |-> $past(ctl_reg[0], 2))
        else $error("line rose with generation off");

    // Main scenarios reached
    cover property ($rose(irq_o));
    cover property (psel_i && penable_i && !pwrite_i && paddr_i == 8'h18);
    cover property (pslverr_o);
endmodule

bind rtc_counter_match_regs rtc_counter_match_regs_sva u_sva (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .irq_o(irq_o)
);

// ---- testbench/apb_host_model.sv ----
`timescale 1ns/1ps
module apb_host_model (
    // Clock
    input  wire        core_clk_i,
    // Requests
    output reg         psel_o    = 1'b0,
    output reg         penable_o = 1'b0,
    output reg         pwrite_o  = 1'b0,
    output reg  [7:0]  paddr_o   = 8'h00,
    output reg  [31:0] pwdata_o  = 32'h0,
    // Answers
    input  wire [31:0] prdata_i,
    input  wire        pready_i,
    input  wire        pslverr_i
);
    // Setup then access, all held until ready is sampled high or eight more edges pass
    task xfer(input w, input [7:0] a, input [31:0] d, output [31:0] q, output e);
        integer n;
        begin
            @(posedge core_clk_i);
            psel_o    <= 1'b1;
            penable_o <= 1'b0;
            pwrite_o  <= w;
            paddr_o   <= a;
            pwdata_o  <= d;
            @(posedge core_clk_i);
            penable_o <= 1'b1;
            n = 0;
            @(posedge core_clk_i);
            // Bounded, so a dead slave cannot hang the bus
            while (pready_i !== 1'b1 && n < 8) begin
                @(posedge core_clk_i);
                n = n + 1;
            end
            q = prdata_i;
            // A ready that never came reads back as unknown, so the caller's check fails
            e = (pready_i === 1'b1) ? pslverr_i : 1'bx;
            psel_o    <= 1'b0;
            penable_o <= 1'b0;
        end
    endtask
endmodule

// ---- testbench/rtc_counter_match_regs_tb_top.sv ----
`timescale 1ns/1ps
`include "rtc_defines.vh"
module rtc_counter_match_regs_tb_top;
    // Clocks and reset
    reg          core_clk = 1'b0;
    reg          arst_n   = 1'b0;
    reg          rtc_clk  = 1'b0;
    // Bus wires
    wire         psel, penable, pwrite, pready, pslverr, irq;
    wire [7:0]   paddr;
    wire [31:0]  pwdata, prdata;
    reg  [31:0]  q;
    reg          e;
    integer      error_cnt  = 0;
    integer      num_checks = 0;
    integer      i;
    // Version word, value arbitrary
    localparam [31:0] VER = 32'h0000ABCD;

    always #5 core_clk = ~core_clk;

    rtc_counter_match_regs #(.VERSION_WORD(VER)) uut (
        .core_clk_i(core_clk), .arst_n_i(arst_n), .rtc_clk_i(rtc_clk),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .irq_o(irq)
    );

    apb_host_model host (
        .core_clk_i(core_clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
        .pslverr_i(pslverr)
    );

    task chk(input string nm, input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("Error %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask

    task wr(input [7:0] a, input [31:0] d);
        begin
            host.xfer(1'b1, a, d, q, e);
            chk("write error", {31'h0, e}, 32'h0);
        end
    endtask

    task rd(input [7:0] a, input [31:0] x);
        begin
            host.xfer(1'b0, a, 32'h0, q, e);
            chk($sformatf("reg %h", a), q, x);
            chk("read error", {31'h0, e}, 32'h0);
        end
    endtask

    // Line is registered, so let two edges land before looking
    task irqis(input [31:0] x);
        begin
            repeat (2) @(posedge core_clk);
            chk("irq line", {31'h0, irq}, x);
        end
    endtask

    // One counter clock period, well under a third of the bus rate
    task tick;
        begin
            @(posedge core_clk);
            rtc_clk <= 1'b1;
            repeat (4) @(posedge core_clk);
            rtc_clk <= 1'b0;
            repeat (4) @(posedge core_clk);
        end
    endtask

    task results;
        begin
            if (error_cnt == 0 && num_checks > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        error_cnt = error_cnt + 1;
        results;
    end

    initial begin
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        // Reset values and the unmapped offset
        for (i = 0; i < 28; i = i + 4)
            rd(i[7:0], 32'h0);
        rd(`OFS_COMP_VERSION, VER);
        host.xfer(1'b0, 8'h20, 32'h0, q, e);
        chk("unmapped error", {31'h0, e}, 32'h1);
        chk("unmapped data", q, 32'h0);
        // Load near the top, count through the roll-over
        wr(`OFS_LOAD_VALUE, 32'hFFFFFFFD);
        wr(`OFS_COUNTER_CONTROL, 32'h4);
        rd(`OFS_COUNTER_VALUE, 32'h0);
        tick;
        rd(`OFS_COUNTER_VALUE, 32'hFFFFFFFD);
        for (i = 0; i < 3; i = i + 1) begin
            tick;
            rd(`OFS_COUNTER_VALUE, 32'hFFFFFFFE + i);
        end
        wr(`OFS_COUNTER_CONTROL, 32'h0);
        tick;
        rd(`OFS_COUNTER_VALUE, 32'h0);
        wr(`OFS_COUNTER_VALUE, 32'h5);
        rd(`OFS_COUNTER_VALUE, 32'h0);
        // Wrap on match with generation off
        wr(`OFS_LOAD_VALUE, 32'hA);
        wr(`OFS_MATCH_VALUE, 32'hC);
        wr(`OFS_COUNTER_CONTROL, 32'hC);
        repeat (4) tick;
        rd(`OFS_RAW_IRQ_STATUS, 32'h0);
        rd(`OFS_COUNTER_VALUE, 32'h0);
        // Same match with generation on
        wr(`OFS_COUNTER_CONTROL, 32'hD);
        wr(`OFS_LOAD_VALUE, 32'hB);
        repeat (3) tick;
        irqis(32'h1);
        rd(`OFS_IRQ_STATUS, 32'h1);
        rd(`OFS_RAW_IRQ_STATUS, 32'h1);
        rd(`OFS_MATCH_VALUE, 32'hC);
        // Mask hides the line and status, raw stays
        wr(`OFS_COUNTER_CONTROL, 32'hF);
        irqis(32'h0);
        rd(`OFS_IRQ_STATUS, 32'h0);
        rd(`OFS_RAW_IRQ_STATUS, 32'h1);
        // Upper control bits are dropped
        wr(`OFS_COUNTER_CONTROL, 32'hFFFFFFFD);
        rd(`OFS_COUNTER_CONTROL, 32'hD);
        // Acknowledge read by software clears the line at once
        host.xfer(1'b0, `OFS_IRQ_ACKNOWLEDGE, 32'h0, q, e);
        irqis(32'h0);
        rd(`OFS_RAW_IRQ_STATUS, 32'h1);
        tick;
        rd(`OFS_RAW_IRQ_STATUS, 32'h0);
        rd(`OFS_IRQ_STATUS, 32'h0);
        results;
    end
endmodule
